// >>> rtl/tcit_pkg.sv
package tcit_pkg;

    localparam logic [15:0] TCIT_ADDR_CH0  = 16'h0040;
    localparam logic [15:0] TCIT_ADDR_CH1  = 16'h0041;
    localparam logic [15:0] TCIT_ADDR_CH2  = 16'h0042;
    localparam logic [15:0] TCIT_ADDR_CTRL = 16'h0043;

    localparam int TCIT_NUM_CH   = 3;
    localparam int TCIT_CMD_LSB  = 4;
    localparam int TCIT_MS_LSB   = 1;
    localparam int TCIT_FMT_BIT  = 0;

    localparam logic [1:0] TCIT_ACC_LATCH = 2'h0;
    localparam logic [1:0] TCIT_ACC_LO    = 2'h1;
    localparam logic [1:0] TCIT_ACC_HI    = 2'h2;
    localparam logic [1:0] TCIT_ACC_WORD  = 2'h3;
    localparam logic [1:0] TCIT_SEL_SPEC  = 2'h3;

    localparam logic [3:0] TCIT_CMD_GEN_LATCH  = 4'hD;
    localparam logic [3:0] TCIT_CMD_STAT_LATCH = 4'hE;
    localparam logic       TCIT_FMT_BCD        = 1'b0;
    localparam logic       TCIT_FMT_BIN        = 1'b1;
    localparam logic [2:0] TCIT_MS_RST         = 3'h0;
    localparam logic [15:0] TCIT_CNT_RST       = 16'h0000;
    localparam logic [15:0] TCIT_CNT_ONE       = 16'h0001;
    localparam logic [15:0] TCIT_CNT_TWO       = 16'h0002;
    localparam logic [7:0] TCIT_BYTE_RST       = 8'h00;
    localparam logic [3:0] TCIT_BCD_TEN        = 4'hA;

    typedef enum logic [5:0] {
        TCIT_M0 = 6'h01,
        TCIT_M1 = 6'h02,
        TCIT_M2 = 6'h04,
        TCIT_M3 = 6'h08,
        TCIT_M4 = 6'h10,
        TCIT_M5 = 6'h20
    } tcit_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } tcit_io_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } tcit_io_rsp_t;

    function automatic tcit_mode_t tcit_mode_of(input logic [2:0] ms);
        tcit_mode_t m;
        m = TCIT_M0;
        unique case (ms)
            3'h0: m = TCIT_M0;
            3'h1: m = TCIT_M1;
            3'h2, 3'h6: m = TCIT_M2; // [RL6]
            3'h3, 3'h7: m = TCIT_M3; // [RL6]
            3'h4: m = TCIT_M4;
            3'h5: m = TCIT_M5;
        endcase
        return m;
    endfunction

    // Steps the count down by one or two; zero wraps round through the top value.
    function automatic logic [15:0] tcit_dec(input logic [15:0] v,
                                             input logic        bcd,
                                             input logic [1:0]  step);
        logic [15:0] r;
        logic [4:0]  d;
        logic [4:0]  b;
        r = v - {14'h0000, step}; // [RL8]
        b = {3'h0, step};
        if (bcd) begin // [RL7]
            for (int i = 0; i < 4; i++) begin
                d = {1'b0, v[4*i +: 4]} - b;
                if (d[4]) begin
                    r[4*i +: 4] = d[3:0] + TCIT_BCD_TEN;
                    b = 5'h01;
                end else begin
                    r[4*i +: 4] = d[3:0];
                    b = 5'h00;
                end
            end
        end
        return r;
    endfunction

endpackage

// >>> rtl/tcit_channel.sv
`timescale 1ns/100ps
module tcit_channel (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic              cfg_wr,
    input  wire tcit_pkg::tcit_mode_t cfg_mode,
    input  wire logic              cfg_bcd,
    input  wire logic              load,
    input  wire logic [15:0]       load_val,
    input  wire logic              tick,
    input  wire logic              gate,
    output logic [15:0]            count,
    output logic                   out,
    output logic                   null_count
);
    import tcit_pkg::*;

    typedef struct packed {
        tcit_mode_t  mode;
        logic        bcd;
        logic [15:0] cnt;
        logic [15:0] reload;
        logic        out;
        logic        have;
        logic        pend;
        logic        run;
        logic        null_c;
        logic        gate_q;
    } tcit_ch_state_t;

    tcit_ch_state_t s_reg;
    tcit_ch_state_t s_next;
    logic [15:0]    even;
    logic [15:0]    dec1;
    logic           trig;

    always_comb begin
        s_next = s_reg;
        trig   = gate & ~s_reg.gate_q;
        even   = {s_reg.reload[15:1], 1'b0};
        dec1   = tcit_dec(s_reg.cnt, s_reg.bcd, 2'h1);
        s_next.gate_q = gate;
        if (cfg_wr) begin
            s_next.mode   = cfg_mode;
            s_next.bcd    = cfg_bcd;
            s_next.out    = (cfg_mode != TCIT_M0);
            s_next.have   = 1'b0;
            s_next.pend   = 1'b0;
            s_next.run    = 1'b0;
            s_next.null_c = 1'b1;
        end else begin
            if (load) begin
                s_next.reload = load_val;
                s_next.have   = 1'b1;
                s_next.null_c = 1'b1;
                if (s_reg.mode inside {TCIT_M0, TCIT_M4} ||
                    (!s_reg.run && s_reg.mode inside {TCIT_M2, TCIT_M3})) begin
                    s_next.pend = 1'b1;
                end
                if (s_reg.mode == TCIT_M0) begin
                    s_next.out = 1'b0;
                end
            end
            if (trig && s_reg.have && s_reg.mode inside
                {TCIT_M1, TCIT_M2, TCIT_M3, TCIT_M5}) begin
                s_next.pend = 1'b1;
            end
            if (tick && s_reg.pend) begin
                s_next.cnt  = (s_reg.mode == TCIT_M3) ? even : s_reg.reload;
                s_next.pend = 1'b0;
                s_next.run  = 1'b1;
                s_next.null_c = load;
                if (s_reg.mode == TCIT_M1) begin
                    s_next.out = 1'b0;
                end
            end else if (tick && s_reg.run) begin
                unique case (s_reg.mode)
                    TCIT_M0: if (gate) begin
                        s_next.cnt = dec1;
                        if (s_reg.cnt == TCIT_CNT_ONE) s_next.out = 1'b1;
                    end
                    TCIT_M1: begin
                        s_next.cnt = dec1;
                        if (s_reg.cnt == TCIT_CNT_ONE) s_next.out = 1'b1;
                    end
                    TCIT_M2: if (gate) begin
                        if (s_reg.cnt == TCIT_CNT_ONE) begin
                            s_next.cnt = s_reg.reload; // [RL9]
                            s_next.out = 1'b1;
                        end else begin
                            s_next.cnt = dec1;
                            s_next.out = (s_reg.cnt != TCIT_CNT_TWO);
                        end
                    end
                    TCIT_M3: if (gate) begin
                        if (s_reg.cnt == TCIT_CNT_TWO) begin
                            s_next.cnt = even; // [RL8]
                            s_next.out = ~s_reg.out;
                        end else begin
                            s_next.cnt = tcit_dec(s_reg.cnt, s_reg.bcd, 2'h2);
                        end
                    end
                    TCIT_M4, TCIT_M5: if (gate || s_reg.mode == TCIT_M5) begin
                        s_next.cnt = dec1;
                        s_next.out = (s_reg.cnt != TCIT_CNT_ONE);
                        if (!s_reg.out) s_next.run = 1'b0;
                    end
                endcase
            end
            if (!gate && s_reg.mode inside {TCIT_M2, TCIT_M3}) begin
                s_next.out = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '{mode: TCIT_M0, bcd: 1'b0, cnt: TCIT_CNT_RST,
                       reload: TCIT_CNT_RST, null_c: 1'b1, default: 1'b0};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign count      = s_reg.cnt;
    assign out        = s_reg.out;
    assign null_count = s_reg.null_c;

endmodule

// >>> rtl/tcit_timer.sv
`timescale 1ns/100ps
// How it works
// [RL1] Three channels each own an 8-bit count port at 40h, 41h, 42h.
// [RL2] One write-only control port at 43h holds command, mode and format.
// [RL3] Command codes 0h, 4h, 8h latch the count of channel 0, 1, 2.
// [RL4] Group offsets 1, 2, 3 pick low byte, high byte or both bytes.
// [RL5] Code Dh latches all counts; code Eh latches all channel status bytes.
// [RL6] Mode bits 3-1 select modes 0-5; 110b acts as 2, 111b as 3.
// [RL7] Format bit 0 set counts binary; clear counts four BCD digits.
// [RL8] Software loads channel 0 in mode 3 with zero, the longest period.
// [RL9] Software runs channel 1 in mode 2 with count 12h for refresh.
// [RL10] Channel 2 output drives the speaker only; channel 0 drives the general timing tick.
// [RL11] Two-byte access moves low byte first, then high, toggling a pointer.
// [RL12] A latched count stays frozen until read out in programmed order.
module tcit_timer (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    input  wire tcit_pkg::tcit_io_req_t io_req,
    input  wire logic [2:0]             cnt_clk_pin,
    input  wire logic [2:0]             gate_pin,
    output tcit_pkg::tcit_io_rsp_t      io_rsp,
    output logic                        tick_out,
    output logic                        refresh_out,
    output logic                        speaker_out
);
    import tcit_pkg::*;

    typedef struct packed {
        logic [1:0]  acc;
        logic [2:0]  ms;
        logic        fmt;
        logic        wr_hi;
        logic        rd_hi;
        logic [7:0]  wr_lo;
        logic        cnt_lat;
        logic [15:0] lat_val;
        logic        st_lat;
        logic [7:0]  st_val;
    } tcit_chan_ctl_t;

    typedef struct packed {
        tcit_chan_ctl_t [2:0] ch;
        logic [2:0]           clk_s1;
        logic [2:0]           clk_s2;
        logic [2:0]           clk_s3;
        logic [2:0]           gate_s1;
        logic [2:0]           gate_s2;
        tcit_io_rsp_t         rsp;
    } tcit_top_state_t;

    localparam tcit_chan_ctl_t CTL_RST = '{
        acc:     TCIT_ACC_WORD,
        ms:      TCIT_MS_RST,
        fmt:     TCIT_FMT_BIN,
        wr_lo:   TCIT_BYTE_RST,
        lat_val: TCIT_CNT_RST,
        st_val:  TCIT_BYTE_RST,
        default: 1'b0
    };

    tcit_top_state_t s_reg;
    tcit_top_state_t s_next;

    logic [15:0] count [TCIT_NUM_CH];
    logic [2:0]  ch_out;
    logic [2:0]  ch_null;
    logic [2:0]  tick;
    logic [2:0]  cfg_wr;
    logic [2:0]  load;
    logic [15:0] load_val;
    tcit_mode_t  cfg_mode;
    logic        cfg_bcd;
    logic [3:0]  cmd;
    logic [1:0]  sel;
    logic [1:0]  acc;
    logic        ctrl_wr;
    logic        port_hit;
    logic [1:0]  port_ch;
    logic [15:0] rd_val;
    logic        rd_high;

    // Tells whether an address is one of the three count ports.
    function automatic logic is_count_port(input logic [15:0] a);
        return (a == TCIT_ADDR_CH0) || (a == TCIT_ADDR_CH1) ||
               (a == TCIT_ADDR_CH2);
    endfunction

    always_comb begin
        s_next   = s_reg;
        cfg_wr   = 3'h0;
        load     = 3'h0;
        load_val = TCIT_CNT_RST;
        rd_val   = TCIT_CNT_RST;
        rd_high  = 1'b0;
        cmd      = io_req.wdata[TCIT_CMD_LSB +: 4];
        sel      = cmd[3:2];
        acc      = cmd[1:0];
        cfg_mode = tcit_mode_of(io_req.wdata[TCIT_MS_LSB +: 3]); // [RL6]
        cfg_bcd  = (io_req.wdata[TCIT_FMT_BIT] == TCIT_FMT_BCD); // [RL7]
        ctrl_wr  = io_req.wr && (io_req.addr == TCIT_ADDR_CTRL); // [RL2]
        port_hit = is_count_port(io_req.addr); // [RL1]
        port_ch  = io_req.addr[1:0];

        // Pin synchronisers; the second and third clock stages form the tick, and the second gate stage feeds the channels.
        s_next.clk_s1  = cnt_clk_pin;
        s_next.clk_s2  = s_reg.clk_s1;
        s_next.clk_s3  = s_reg.clk_s2;
        s_next.gate_s1 = gate_pin;
        s_next.gate_s2 = s_reg.gate_s1;
        tick = s_reg.clk_s2 & ~s_reg.clk_s3;

        s_next.rsp.valid = 1'b0;

        if (ctrl_wr) begin
            for (int i = 0; i < TCIT_NUM_CH; i++) begin
                if (sel == 2'(i) && acc == TCIT_ACC_LATCH) begin
                    if (!s_reg.ch[i].cnt_lat) begin // [RL3]
                        s_next.ch[i].cnt_lat = 1'b1;
                        s_next.ch[i].lat_val = count[i];
                    end
                end else if (sel == 2'(i)) begin
                    s_next.ch[i].acc     = acc; // [RL4]
                    s_next.ch[i].ms      = io_req.wdata[TCIT_MS_LSB +: 3];
                    s_next.ch[i].fmt     = io_req.wdata[TCIT_FMT_BIT];
                    s_next.ch[i].wr_hi   = 1'b0;
                    s_next.ch[i].rd_hi   = 1'b0;
                    s_next.ch[i].cnt_lat = 1'b0;
                    s_next.ch[i].st_lat  = 1'b0;
                    cfg_wr[i]            = 1'b1;
                end else if (sel == TCIT_SEL_SPEC) begin
                    if (cmd == TCIT_CMD_GEN_LATCH &&
                        !s_reg.ch[i].cnt_lat) begin // [RL5]
                        s_next.ch[i].cnt_lat = 1'b1;
                        s_next.ch[i].lat_val = count[i];
                    end
                    if (cmd == TCIT_CMD_STAT_LATCH &&
                        !s_reg.ch[i].st_lat) begin // [RL5]
                        s_next.ch[i].st_lat = 1'b1;
                        s_next.ch[i].st_val = {ch_out[i], ch_null[i],
                                               s_reg.ch[i].acc,
                                               s_reg.ch[i].ms,
                                               s_reg.ch[i].fmt};
                    end
                end
            end
        end

        if (io_req.wr && port_hit) begin
            for (int i = 0; i < TCIT_NUM_CH; i++) begin
                if (port_ch == 2'(i)) begin
                    unique case (s_reg.ch[i].acc)
                        TCIT_ACC_LO: begin // [RL4]
                            load[i]  = 1'b1;
                            load_val = {TCIT_BYTE_RST, io_req.wdata};
                        end
                        TCIT_ACC_HI: begin // [RL4]
                            load[i]  = 1'b1;
                            load_val = {io_req.wdata, TCIT_BYTE_RST};
                        end
                        TCIT_ACC_WORD: begin
                            if (!s_reg.ch[i].wr_hi) begin // [RL11]
                                s_next.ch[i].wr_lo = io_req.wdata;
                                s_next.ch[i].wr_hi = 1'b1;
                            end else begin
                                load[i]  = 1'b1;
                                load_val = {io_req.wdata,
                                            s_reg.ch[i].wr_lo};
                                s_next.ch[i].wr_hi = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        if (io_req.rd && (port_hit || io_req.addr == TCIT_ADDR_CTRL)) begin
            s_next.rsp.valid = 1'b1;
            s_next.rsp.data  = TCIT_BYTE_RST;
        end
        if (io_req.rd && port_hit) begin
            for (int i = 0; i < TCIT_NUM_CH; i++) begin
                if (port_ch == 2'(i)) begin
                    rd_val  = s_reg.ch[i].cnt_lat ? s_reg.ch[i].lat_val
                                                  : count[i];
                    rd_high = (s_reg.ch[i].acc == TCIT_ACC_HI) ||
                              (s_reg.ch[i].acc == TCIT_ACC_WORD &&
                               s_reg.ch[i].rd_hi); // [RL11]
                    if (s_reg.ch[i].st_lat) begin // [RL5]
                        s_next.rsp.data     = s_reg.ch[i].st_val;
                        s_next.ch[i].st_lat = 1'b0;
                    end else begin
                        s_next.rsp.data = rd_high ? rd_val[15:8]
                                                  : rd_val[7:0];
                        if (s_reg.ch[i].acc == TCIT_ACC_WORD) begin
                            s_next.ch[i].rd_hi = ~s_reg.ch[i].rd_hi;
                        end
                        if (s_reg.ch[i].acc != TCIT_ACC_WORD ||
                            s_reg.ch[i].rd_hi) begin // [RL12]
                            s_next.ch[i].cnt_lat = 1'b0;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg.ch      <= {CTL_RST, CTL_RST, CTL_RST};
            s_reg.clk_s1  <= 3'h0;
            s_reg.clk_s2  <= 3'h0;
            s_reg.clk_s3  <= 3'h0;
            s_reg.gate_s1 <= 3'h0;
            s_reg.gate_s2 <= 3'h0;
            s_reg.rsp     <= '{data: TCIT_BYTE_RST, valid: 1'b0};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    genvar g;
    for (g = 0; g < TCIT_NUM_CH; g++) begin : g_ch
        tcit_channel u_ch (
            .clk        (clk),
            .rst        (rst),
            .clk_en     (clk_en),
            .cfg_wr     (cfg_wr[g]),
            .cfg_mode   (cfg_mode),
            .cfg_bcd    (cfg_bcd),
            .load       (load[g]),
            .load_val   (load_val),
            .tick       (tick[g]),
            .gate       (s_reg.gate_s2[g]),
            .count      (count[g]),
            .out        (ch_out[g]),
            .null_count (ch_null[g])
        );
    end

    assign io_rsp      = s_reg.rsp;
    assign tick_out    = ch_out[0];
    assign refresh_out = ch_out[1];
    assign speaker_out = ch_out[2]; // [RL10]

endmodule

// >>> tb/tcit_timer_sva.sv
`timescale 1ns/100ps
module tcit_timer_sva (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   clk_en,
    input wire tcit_pkg::tcit_io_req_t io_req,
    input wire logic [2:0]             cnt_clk_pin,
    input wire logic [2:0]             gate_pin,
    input wire tcit_pkg::tcit_io_rsp_t io_rsp,
    input wire logic                   tick_out,
    input wire logic                   refresh_out,
    input wire logic                   speaker_out
);
    import tcit_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       rd_ok;
    logic [2:0] pins_reg;
    logic [2:0] gates_reg;
    logic [2:0] quiet_reg;
    assign rd_ok = clk_en && io_req.rd && io_req.addr >= TCIT_ADDR_CH0
                   && io_req.addr <= TCIT_ADDR_CTRL;
    // Counts edges since the last event that may move a channel output.
    // A frozen stretch restarts it, since synced edges resume afterwards.
    always_ff @(posedge clk) begin
        pins_reg  <= cnt_clk_pin;
        gates_reg <= gate_pin;
        if (rst || !clk_en || (cnt_clk_pin & ~pins_reg) != 3'h0
            || gate_pin != gates_reg || io_req.wr) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    property p_rd_answer;
        rd_ok |=> io_rsp.valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("count port read got no answer");
    property p_no_spurious;
        io_rsp.valid && $past(clk_en) |-> $past(rd_ok);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without a mapped read");
    property p_wr_silent;
        clk_en && io_req.wr && !io_req.rd |=> !io_rsp.valid;
    endproperty
    a_wr_silent: assert property (p_wr_silent)
        else $error("write produced an answer");
    property p_ctrl_zero;
        rd_ok && io_req.addr == TCIT_ADDR_CTRL |=> io_rsp.data == 8'h00;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control port read not zero");
    property p_data_hold;
        !io_rsp.valid |-> $stable(io_rsp.data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("read data moved without an answer");
    property p_freeze;
        !clk_en |=> $stable(io_rsp)
                    && $stable({tick_out, refresh_out, speaker_out});
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("outputs moved while disabled");
    property p_back_to_back;
        rd_ok ##1 rd_ok |-> io_rsp.valid ##1 io_rsp.valid;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("back to back reads not both answered");
    property p_quiet;
        quiet_reg == 3'h7 |-> $stable({tick_out, refresh_out, speaker_out});
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("channel output moved without a cause");
endmodule

bind tcit_timer tcit_timer_sva i_tcit_timer_sva (
    .clk         (clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .io_req      (io_req),
    .cnt_clk_pin (cnt_clk_pin),
    .gate_pin    (gate_pin),
    .io_rsp      (io_rsp),
    .tick_out    (tick_out),
    .refresh_out (refresh_out),
    .speaker_out (speaker_out)
);

// >>> tb/tcit_host.sv
`timescale 1ns/100ps
module tcit_host (
    input  wire logic              clk,
    output tcit_pkg::tcit_io_req_t io_req
);
    import tcit_pkg::*;
    initial io_req = '0;
    // Holds one request from a falling edge through the taking rising edge.
    task automatic xfer(input logic [15:0] a, input logic w, input logic r,
                        input logic [7:0] d);
        @(negedge clk);
        io_req <= '{addr: a, wr: w, rd: r, wdata: d};
        @(posedge clk);
    endtask
    // Released address and data lines show the inverse of their last value; wr and rd drop to 0.
    task automatic idle();
        @(negedge clk);
        io_req <= '{addr: ~io_req.addr, wr: 1'b0, rd: 1'b0,
                    wdata: ~io_req.wdata};
    endtask
endmodule

// >>> tb/three_channel_interval_timer_test.sv
`timescale 1ns/100ps
module three_channel_interval_timer_test;
    import tcit_pkg::*;
    logic         clk;
    logic         rst;
    logic         clk_en;
    logic [2:0]   cnt_clk_pin;
    logic [2:0]   gate_pin;
    tcit_io_req_t io_req;
    tcit_io_rsp_t io_rsp;
    logic         tick_out;
    logic         refresh_out;
    logic         speaker_out;
    int           failures;
    int           checks;
    logic [7:0]   exp_q[$];
    logic [15:0]  rv;

    tcit_timer i_tcit_timer (
        .clk         (clk),
        .rst         (rst),
        .clk_en      (clk_en),
        .io_req      (io_req),
        .cnt_clk_pin (cnt_clk_pin),
        .gate_pin    (gate_pin),
        .io_rsp      (io_rsp),
        .tick_out    (tick_out),
        .refresh_out (refresh_out),
        .speaker_out (speaker_out)
    );
    tcit_host i_tcit_host (.clk(clk), .io_req(io_req));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic compare_byte(input string what, input logic [7:0] e,
                                input logic [7:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic compare_bit(input string what, input logic e,
                               input logic s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_tcit_host.xfer(a, 1'b1, 1'b0, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_tcit_host.xfer(a, 1'b0, 1'b1, 8'h00);
    endtask
    task automatic tick(input int ch, input int n);
        i_tcit_host.idle();
        repeat (n) begin
            @(negedge clk);
            cnt_clk_pin[ch] = 1'b1;
            repeat (3) @(negedge clk);
            cnt_clk_pin[ch] = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask

    // Every answer takes the oldest expected byte off the queue.
    always @(posedge clk) begin
        if (!rst && io_rsp.valid !== 1'b0) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("BAD io_rsp.valid expected 0 seen 1");
            end else begin
                compare_byte("io_rsp.data", exp_q.pop_front(), io_rsp.data);
            end
        end
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        cnt_clk_pin = 3'h0;
        gate_pin = 3'h7;
        failures = 0;
        checks = 0;
        void'($urandom(32'hA258));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd(TCIT_ADDR_CTRL, 8'h00);
        i_tcit_host.xfer(16'h0044, 1'b0, 1'b1, 8'h00);
        i_tcit_host.idle();
        clk_en = 1'b0;
        i_tcit_host.xfer(TCIT_ADDR_CH0, 1'b0, 1'b1, 8'h00);
        i_tcit_host.idle();
        clk_en = 1'b1;
        wr(TCIT_ADDR_CTRL, 8'h75);
        wr(TCIT_ADDR_CH1, 8'h34);
        wr(TCIT_ADDR_CH1, 8'h12);
        tick(1, 1);
        wr(TCIT_ADDR_CTRL, 8'h40);
        rd(TCIT_ADDR_CH1, 8'h34);
        tick(1, 2);
        rd(TCIT_ADDR_CH1, 8'h12);
        rd(TCIT_ADDR_CH1, 8'h32);
        rd(TCIT_ADDR_CH1, 8'h12);
        wr(TCIT_ADDR_CTRL, 8'h31);
        repeat (4) begin
            rv = 16'($urandom);
            wr(TCIT_ADDR_CH0, rv[7:0]);
            wr(TCIT_ADDR_CH0, rv[15:8]);
            tick(0, 1);
            wr(TCIT_ADDR_CTRL, 8'h00);
            rd(TCIT_ADDR_CH0, rv[7:0]);
            rd(TCIT_ADDR_CH0, rv[15:8]);
        end
        wr(TCIT_ADDR_CTRL, 8'h91);
        wr(TCIT_ADDR_CH2, 8'h57);
        tick(2, 1);
        wr(TCIT_ADDR_CTRL, 8'h80);
        rd(TCIT_ADDR_CH2, 8'h57);
        wr(TCIT_ADDR_CTRL, 8'hA1);
        wr(TCIT_ADDR_CH2, 8'h23);
        tick(2, 1);
        wr(TCIT_ADDR_CTRL, 8'h80);
        rd(TCIT_ADDR_CH2, 8'h23);
        rd(TCIT_ADDR_CH2, 8'h23);
        wr(TCIT_ADDR_CTRL, 8'h30);
        wr(TCIT_ADDR_CH0, 8'h00);
        wr(TCIT_ADDR_CH0, 8'h10);
        tick(0, 2);
        wr(TCIT_ADDR_CTRL, 8'h00);
        rd(TCIT_ADDR_CH0, 8'h99);
        rd(TCIT_ADDR_CH0, 8'h09);
        // A gate rise arms modes 1 and 5; mode 1 drives low once loaded.
        for (int ms = 0; ms < 8; ms++) begin
            wr(TCIT_ADDR_CTRL, {4'hB, 3'(ms), 1'b1});
            wr(TCIT_ADDR_CH2, 8'h10);
            wr(TCIT_ADDR_CH2, 8'h00);
            i_tcit_host.idle();
            gate_pin[2] = 1'b0;
            repeat (3) @(negedge clk);
            gate_pin[2] = 1'b1;
            tick(2, 1);
            compare_bit("speaker_out", ms > 1, speaker_out);
        end
        wr(TCIT_ADDR_CTRL, 8'hE0);
        rd(TCIT_ADDR_CH0, 8'h30);
        rd(TCIT_ADDR_CH0, 8'h99);
        rd(TCIT_ADDR_CH0, 8'h09);
        rd(TCIT_ADDR_CH1, 8'hB5);
        rd(TCIT_ADDR_CH2, 8'hBF);
        wr(TCIT_ADDR_CTRL, 8'hD0);
        tick(1, 1);
        rd(TCIT_ADDR_CH1, 8'h32);
        rd(TCIT_ADDR_CH1, 8'h12);
        wr(TCIT_ADDR_CTRL, 8'h37);
        wr(TCIT_ADDR_CH0, 8'h00);
        wr(TCIT_ADDR_CH0, 8'h00);
        wr(TCIT_ADDR_CTRL, 8'h75);
        wr(TCIT_ADDR_CH1, 8'h12);
        wr(TCIT_ADDR_CH1, 8'h00);
        tick(0, 2);
        compare_bit("tick_out", 1'b1, tick_out);
        wr(TCIT_ADDR_CTRL, 8'h00);
        rd(TCIT_ADDR_CH0, 8'hFE);
        rd(TCIT_ADDR_CH0, 8'hFF);
        tick(1, 1);
        compare_bit("refresh_out", 1'b1, refresh_out);
        tick(1, 17);
        compare_bit("refresh_out", 1'b0, refresh_out);
        tick(1, 1);
        compare_bit("refresh_out", 1'b1, refresh_out);
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk);
        if (exp_q.size() != 0) begin
            failures++;
            $display("BAD pending_answers expected 0 seen %0d", exp_q.size());
        end
        report_and_stop();
    end
endmodule
